//--- testbench/ccu_pin_model.sv
// Far-side pin model: capture pins and external reload input
`timescale 1ns/10ps
module ccu_pin_model (
  // Clock
  input  wire logic       mclk_i,
  // Unit compare outputs
  input  wire logic [4:0] cc_out_i,
  input  wire logic [4:0] cc_oe_i,
  // Pins seen by the unit
  output logic      [4:0] cc_pin_o,
  output logic            rld_pin_o
);
  logic [4:0] drv;
  // Pulled-up pins, unit output wins while enabled
  assign cc_pin_o = (cc_oe_i & cc_out_i) | (~cc_oe_i & drv);
  initial begin
    drv       = 5'h1f;
    rld_pin_o = 1'b1;
  end
  task automatic set_pin(input int idx, input logic lvl);
    @(negedge mclk_i);
    drv[idx] = lvl;
    repeat (6) @(negedge mclk_i);
  endtask
  task automatic reload_pulse();
    @(negedge mclk_i);
    rld_pin_o = 1'b0;
    repeat (6) @(negedge mclk_i);
    rld_pin_o = 1'b1;
  endtask
endmodule

//--- testbench/compare_capture_unit_tb_top.sv
// Self-checking testbench of the compare/capture unit
`timescale 1ns/10ps
module compare_capture_unit_tb_top;
  logic        mclk_i, rst_i, t2_run_i, ct_run_i, reg_wr_i, reg_hi_i;
  logic [1:0]  t2_presc_i, t2_rld_mode_i;
  logic [2:0]  ct_presc_i;
  logic [15:0] ct_reload_i, rd_data_o, vec_o, rv;
  logic [3:0]  reg_idx_i, rd_idx_i;
  logic [7:0]  reg_data_i, cm_en_i, cm_sel_i, cm_level_i, ccm_en_i, ccm_level_i;
  logic [9:0]  cc_mode_i;
  logic [4:0]  cc_cmode1_i, cc_level_i, cc_pin_i, cc_out_o, cc_oe_o;
  logic        ext_irq_two_flag_rise_i, ext_irq_three_flag_rise_i, rld_pin;
  logic [7:0]  cm_out_o, ccm_out_o, flag_clr_i, flags_o;
  logic [6:0]  irq_o;
  int          num_errors, check_count, cyc;

  ccu_top #(.T2_DIV(12)) u_ccu_top (
    .mclk_i(mclk_i), .rst_i(rst_i), .t2_run_i(t2_run_i), .t2_presc_i(t2_presc_i),
    .t2_rld_mode_i(t2_rld_mode_i), .external_reload_input_i(rld_pin),
    .ct_run_i(ct_run_i), .ct_presc_i(ct_presc_i), .ct_reload_i(ct_reload_i),
    .reg_wr_i(reg_wr_i), .reg_hi_i(reg_hi_i), .reg_idx_i(reg_idx_i),
    .reg_data_i(reg_data_i), .rd_idx_i(rd_idx_i), .rd_data_o(rd_data_o),
    .cc_mode_i(cc_mode_i), .cc_cmode1_i(cc_cmode1_i), .cc_level_i(cc_level_i),
    .cm_en_i(cm_en_i), .cm_sel_i(cm_sel_i), .cm_level_i(cm_level_i),
    .ccm_en_i(ccm_en_i), .ccm_level_i(ccm_level_i), .ext_irq_two_flag_rise_i(ext_irq_two_flag_rise_i),
    .ext_irq_three_flag_rise_i(ext_irq_three_flag_rise_i), .cc_pin_i(cc_pin_i), .cc_out_o(cc_out_o),
    .cc_oe_o(cc_oe_o), .cm_out_o(cm_out_o), .ccm_out_o(ccm_out_o),
    .flag_clr_i(flag_clr_i), .flags_o(flags_o), .irq_o(irq_o), .vec_o(vec_o));

  ccu_pin_model u_ccu_pin_model (
    .mclk_i(mclk_i), .cc_out_i(cc_out_o), .cc_oe_i(cc_oe_o),
    .cc_pin_o(cc_pin_i), .rld_pin_o(rld_pin));

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Run limit
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] idx, input logic hi, input logic [7:0] d);
    @(negedge mclk_i);
    reg_wr_i = 1'b1;
    reg_hi_i = hi;
    reg_idx_i = idx;
    reg_data_i = d;
    @(negedge mclk_i);
    reg_wr_i = 1'b0;
  endtask

  task automatic wr16(input logic [3:0] idx, input logic [15:0] v);
    wr(idx, 1'b1, v[15:8]);
    wr(idx, 1'b0, v[7:0]);
  endtask

  task automatic rd(input logic [3:0] idx);
    @(negedge mclk_i);
    rd_idx_i = idx;
    repeat (2) @(negedge mclk_i);
    rv = rd_data_o;
  endtask

  task automatic wait_flag(input int b);
    int n;
    n = 0;
    while (flags_o[b] !== 1'b1 && n < 200) begin
      @(negedge mclk_i);
      n++;
    end
  endtask

  task automatic wait_cc(input int b, input logic v);
    int n;
    n = 0;
    while (cc_out_o[b] !== v && n < 200) begin
      @(negedge mclk_i);
      n++;
    end
  endtask

  task automatic clear_flags();
    @(negedge mclk_i);
    flag_clr_i = 8'hff;
    @(negedge mclk_i);
    flag_clr_i = 8'h00;
    @(negedge mclk_i);
    chk("flags clear", 16'h0000, 16'(flags_o));
  endtask

  task automatic t_regs();
    chk("flags reset", 16'h0000, 16'(flags_o));
    chk("cc out reset", 16'h0000, 16'(cc_out_o));
    wr16(4'h0, 16'hfff0);
    rd(4'h0);
    chk("reload reg", 16'hfff0, rv);
    wr16(4'hd, 16'h1234);
    rd(4'hd);
    chk("timer 2 idle", 16'h0000, rv);
    rd(4'hf);
    chk("unmapped", 16'h0000, rv);
  endtask

  task automatic t_ext_irq();
    u_ccu_pin_model.set_pin(4, 1'b0);
    chk("irq 2 falling", 16'h0001, 16'(flags_o[3]));
    u_ccu_pin_model.set_pin(4, 1'b1);
    u_ccu_pin_model.set_pin(0, 1'b0);
    chk("irq 3 on fall", 16'h0000, 16'(flags_o[4]));
    u_ccu_pin_model.set_pin(0, 1'b1);
    chk("irq 3 rising", 16'h0001, 16'(flags_o[4]));
    clear_flags();
  endtask

  task automatic t_ext_reload();
    t2_rld_mode_i = 2'd2;
    u_ccu_pin_model.reload_pulse();
    wait_flag(1);
    rd(4'hd);
    chk("timer 2 reloaded", 16'hfff0, rv);
    chk("irq shared", 16'h0001, 16'(irq_o[0]));
    chk("vector", 16'h002b, vec_o);
    clear_flags();
  endtask

  task automatic t_capture();
    cc_mode_i = 10'h010;
    u_ccu_pin_model.set_pin(2, 1'b0);
    u_ccu_pin_model.set_pin(2, 1'b1);
    wait_flag(6);
    rd(4'h2);
    chk("pin capture", 16'hfff0, rv);
    cc_mode_i = 10'h0c0;
    wr(4'h3, 1'b0, 8'h55);
    rd(4'h3);
    chk("write capture", 16'hfff0, rv);
    cc_mode_i = 10'h000;
    clear_flags();
  endtask

  task automatic t_compare();
    cc_mode_i = 10'h208;
    cc_cmode1_i = 5'h10;
    cc_level_i = 5'h10;
    wr16(4'h1, 16'hfff8);
    wr16(4'h4, 16'hfff4);
    wr16(4'h5, 16'hfff6);
    cm_en_i = 8'h01;
    cm_level_i = 8'h01;
    ccm_en_i = 8'h01;
    ccm_level_i = 8'h01;
    t2_rld_mode_i = 2'd1;
    t2_run_i = 1'b1;
    wait_cc(1, 1'b1);
    chk("mode 0 match", 16'h0001, 16'(cc_out_o[1]));
    chk("output enables", 16'h0012, 16'(cc_oe_o));
    @(negedge mclk_i);
    chk("match flag", 16'h0001, 16'(flags_o[5]));
    chk("mode 1 level", 16'h0001, 16'(cc_out_o[4]));
    chk("general on t2", 16'h0001, 16'(cm_out_o[0]));
    chk("port 5 line", 16'h0001, 16'(ccm_out_o[0]));
    wait_flag(0);
    wait_cc(1, 1'b0);
    chk("mode 0 overflow", 16'h0000, 16'(cc_out_o[1]));
    chk("mode 1 holds", 16'h0001, 16'(cc_out_o[4]));
    t2_run_i = 1'b0;
    rd(4'hd);
    chk("auto reload", 16'h0fff, {4'h0, rv[15:4]});
  endtask

  task automatic t_ct();
    ct_presc_i = 3'd1;
    @(negedge mclk_i);
    ct_run_i = 1'b1;
    repeat (40) @(negedge mclk_i);
    ct_run_i = 1'b0;
    rd(4'he);
    chk("compare timer rate", 16'h000a, rv);
  endtask

  initial begin
    num_errors = 0;
    check_count = 0;
    cyc = 0;
    rst_i = 1'b1;
    {t2_run_i, ct_run_i, reg_wr_i, reg_hi_i, ext_irq_two_flag_rise_i} = 5'h00;
    ext_irq_three_flag_rise_i = 1'b1;
    {t2_presc_i, t2_rld_mode_i, ct_presc_i} = 7'h00;
    {ct_reload_i, reg_idx_i, rd_idx_i, reg_data_i} = 32'h0;
    {cm_en_i, cm_sel_i, cm_level_i, ccm_en_i, ccm_level_i} = 40'h0;
    {cc_mode_i, cc_cmode1_i, cc_level_i, flag_clr_i} = 28'h0;
    repeat (10) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    t_regs();
    t_ext_irq();
    t_ext_reload();
    t_capture();
    t_compare();
    t_ct();
    report_and_stop();
  end
endmodule

//--- verilog/ccu_cmp_chan.sv
// One compare channel with optional shadow latch
`timescale 1ns/10ps
`include "ccu_regs.svh"
module ccu_cmp_chan (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Channel signals
  ccu_cmp_if.chan  bus
);
  logic [15:0] shadow;
  logic        match;
  logic        out_q;
  logic        hit_q;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      shadow <= `CCU_RST16;
    end else if (bus.ovf) begin
      shadow <= bus.val;
    end
  end

  assign match = bus.en && bus.upd && (bus.tmr == (bus.latch ? shadow : bus.val));

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      out_q <= 1'b0;
    end else if (!bus.en) begin
      out_q <= 1'b0;
    end else if (match) begin
      out_q <= bus.mode1 ? bus.level : 1'b1;
    end else if (bus.ovf && !bus.mode1) begin
      out_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= match;
    end
  end

  assign bus.out = out_q;
  assign bus.hit = hit_q;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  property p_set0;
    match && !bus.mode1 |=> bus.out && bus.hit;
  endproperty
  a_set0: assert property (p_set0) else $error("mode 0 match did not set");
  property p_clr0;
    bus.en && bus.ovf && !bus.mode1 && !match |=> !bus.out;
  endproperty
  a_clr0: assert property (p_clr0) else $error("mode 0 overflow did not clear");
  property p_lvl1;
    match && bus.mode1 |=> bus.out == $past(bus.level);
  endproperty
  a_lvl1: assert property (p_lvl1) else $error("mode 1 level wrong");
  property p_keep1;
    bus.en && bus.ovf && bus.mode1 && !match |=> bus.out == $past(bus.out);
  endproperty
  a_keep1: assert property (p_keep1) else $error("mode 1 overflow changed output");
  property p_shadow;
    bus.ovf |=> shadow == $past(bus.val);
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow latch not loaded");
  c_mode0: cover property (match && !bus.mode1 ##[1:300] bus.ovf);
endmodule

//--- verilog/ccu_cmp_if.sv
// Signals between the unit and one compare channel
`timescale 1ns/10ps
interface ccu_cmp_if;
  logic [15:0] tmr;
  logic [15:0] val;
  logic        upd;
  logic        ovf;
  logic        en;
  logic        mode1;
  logic        level;
  logic        latch;
  logic        out;
  logic        hit;
  modport chan (input tmr, val, upd, ovf, en, mode1, level, latch, output out, hit);
  modport ctl (output tmr, val, upd, ovf, en, mode1, level, latch, input out, hit);
endinterface

//--- verilog/ccu_pkg.sv
// Types of the compare/capture unit
package ccu_pkg;
  typedef enum logic [1:0] {CC_OFF, CC_CAP_PIN, CC_COMPARE, CC_CAP_WRITE} ccu_cc_mode_t;
  typedef enum logic [1:0] {RLD_OFF, RLD_AUTO, RLD_EXT} ccu_rld_t;
endpackage

//--- verilog/ccu_regs.svh
// Constants of the compare/capture unit
// Function
// - Timer 2: 16 bits, prescaler, max fosc/12
// - Compare timer: 16 bits, prescaler, max fosc/2
// - Thirteen compare registers, five also capture
// - 21 output lines, seven interrupt requests
// - Each general compare register selects its timer
// - Compare/capture and reload registers use timer 2
// - Compare/capture match gives output action and interrupt request
// - Mode 0: high on match, low on overflow
// - Mode 1: software level, overflow ignored
// - Mode 0 general registers use overflow-loaded latches
// - Compare timer means mode 0, timer 2 mode 1
// - Capture mode 0: pin edge latches timer 2
// - Capture mode 1: low write latches timer 2
// - Reload value is high and low byte
// - Reload mode 0: reload on timer 2 overflow
// - Reload mode 1: falling reload input edge
// - Overflow and reload flags share one vector
// - Ext interrupts 2, 3 edge selectable, shared pins
`ifndef CCU_REGS_SVH
`define CCU_REGS_SVH
`define CCU_T2_DIV 12
`define CCU_CT_DIV_LAST 1'b1
`define CCU_NUM_CC 5
`define CCU_NUM_CM 8
`define CCU_NUM_CH 13
`define CCU_IDX_T2 4'd13
`define CCU_IDX_CT 4'd14
`define CCU_TMR_MAX 16'hffff
`define CCU_RST16 16'h0000
`define CCU_VEC_T2 16'h002b
`define CCU_VEC_CT 16'h009b
`define CCU_VEC_NONE 16'h0000
`endif

//--- verilog/ccu_top.sv
// Compare/capture unit: two timers, thirteen compare channels
`timescale 1ns/10ps
`include "ccu_regs.svh"
module ccu_top #(
  parameter int T2_DIV = `CCU_T2_DIV
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // Timer 2 control
  input  wire logic        t2_run_i,
  input  wire logic [1:0]  t2_presc_i,
  input  wire logic [1:0]  t2_rld_mode_i,
  input  wire logic        external_reload_input_i,
  // Compare timer control
  input  wire logic        ct_run_i,
  input  wire logic [2:0]  ct_presc_i,
  input  wire logic [15:0] ct_reload_i,
  // Register write and read
  input  wire logic        reg_wr_i,
  input  wire logic        reg_hi_i,
  input  wire logic [3:0]  reg_idx_i,
  input  wire logic [7:0]  reg_data_i,
  input  wire logic [3:0]  rd_idx_i,
  output logic      [15:0] rd_data_o,
  // Channel configuration
  input  wire logic [9:0]  cc_mode_i,
  input  wire logic [4:0]  cc_cmode1_i,
  input  wire logic [4:0]  cc_level_i,
  input  wire logic [7:0]  cm_en_i,
  input  wire logic [7:0]  cm_sel_i,
  input  wire logic [7:0]  cm_level_i,
  input  wire logic [7:0]  ccm_en_i,
  input  wire logic [7:0]  ccm_level_i,
  input  wire logic        ext_irq_two_flag_rise_i,
  input  wire logic        ext_irq_three_flag_rise_i,
  // Capture pins
  input  wire logic [4:0]  cc_pin_i,
  // Compare outputs
  output logic      [4:0]  cc_out_o,
  output logic      [4:0]  cc_oe_o,
  output logic      [7:0]  cm_out_o,
  output logic      [7:0]  ccm_out_o,
  // Interrupt requests
  input  wire logic [7:0]  flag_clr_i,
  output logic      [7:0]  flags_o,
  output logic      [6:0]  irq_o,
  output logic      [15:0] vec_o
);
  localparam int NCC = `CCU_NUM_CC;
  localparam int NCH = `CCU_NUM_CH;

  if (T2_DIV < 12 || T2_DIV > 16) begin : g_bad_div
    $error("T2_DIV must be 12 to 16");
  end

  logic [15:0] creg [NCH];
  logic [15:0] t2;
  logic [15:0] ct;
  logic [3:0]  d12;
  logic [2:0]  pre2;
  logic [2:0]  t2_mask;
  logic        d2;
  logic [7:0]  pre8;
  logic [7:0]  ct_mask;
  logic        t2_tick;
  logic        ct_tick;
  logic        t2_ovf;
  logic        ct_ovf;
  logic        ext_rld;
  logic        t2_upd;
  logic        t2_ovf_q;
  logic        ct_upd;
  logic        ct_ovf_q;
  logic [2:0]  t2x_s;
  logic [4:0]  pin_s1;
  logic [4:0]  pin_s2;
  logic [4:0]  pin_s3;
  logic [4:0]  fall_sel;
  logic [4:0]  pin_edge;
  logic [4:0]  iex_ev;
  logic [NCH-1:0] cap_now;
  logic [NCH-1:0] ch_out;
  logic [NCH-1:0] ch_hit;
  logic [4:0]  oe_next;
  logic [7:0]  ccm_mask;
  logic [7:0]  flags;
  logic [7:0]  flag_set;
  ccu_pkg::ccu_cc_mode_t cc_mode [NCC];
  ccu_pkg::ccu_rld_t     rld;

  assign rld = ccu_pkg::ccu_rld_t'(t2_rld_mode_i);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      d12 <= 4'h0;
      pre2 <= 3'h0;
    end else if (t2_run_i) begin
      if (d12 == 4'(T2_DIV - 1)) begin
        d12 <= 4'h0;
        pre2 <= pre2 + 3'h1;
      end else begin
        d12 <= d12 + 4'h1;
      end
    end
  end

  assign t2_mask = 3'((4'h1 << t2_presc_i) - 4'h1);
  assign t2_tick = t2_run_i && (d12 == 4'(T2_DIV - 1)) && ((pre2 & t2_mask) == 3'h0);
  assign t2_ovf = t2_tick && (t2 == `CCU_TMR_MAX);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      d2 <= 1'b0;
      pre8 <= 8'h00;
    end else if (ct_run_i) begin
      d2 <= ~d2;
      if (d2 == `CCU_CT_DIV_LAST) begin
        pre8 <= pre8 + 8'h01;
      end
    end
  end

  assign ct_mask = 8'((9'h001 << ct_presc_i) - 9'h001);
  assign ct_tick = ct_run_i && (d2 == `CCU_CT_DIV_LAST) && ((pre8 & ct_mask) == 8'h00);
  assign ct_ovf = ct_tick && (ct == `CCU_TMR_MAX);

  // Pin synchronisers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      t2x_s <= 3'h7;
      pin_s1 <= 5'h1f;
      pin_s2 <= 5'h1f;
      pin_s3 <= 5'h1f;
    end else begin
      t2x_s <= {t2x_s[1:0], external_reload_input_i};
      pin_s1 <= cc_pin_i;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  assign ext_rld = (rld == ccu_pkg::RLD_EXT) && t2x_s[2] && !t2x_s[1];

  assign fall_sel = {~ext_irq_two_flag_rise_i, 3'b000, ~ext_irq_three_flag_rise_i};
  assign pin_edge = (pin_s2 & ~pin_s3 & ~fall_sel) | (~pin_s2 & pin_s3 & fall_sel);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      t2 <= `CCU_RST16;
    end else if (ext_rld) begin
      t2 <= creg[0];
    end else if (t2_ovf) begin
      t2 <= (rld == ccu_pkg::RLD_AUTO) ? creg[0] : `CCU_RST16;
    end else if (t2_tick) begin
      t2 <= t2 + 16'h0001;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ct <= `CCU_RST16;
    end else if (ct_ovf) begin
      ct <= ct_reload_i;
    end else if (ct_tick) begin
      ct <= ct + 16'h0001;
    end
  end

  // Update and overflow strobes for the channels
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      t2_upd <= 1'b0;
      t2_ovf_q <= 1'b0;
      ct_upd <= 1'b0;
      ct_ovf_q <= 1'b0;
    end else begin
      t2_upd <= t2_tick | ext_rld;
      t2_ovf_q <= t2_ovf;
      ct_upd <= ct_tick;
      ct_ovf_q <= ct_ovf;
    end
  end

  for (genvar i = 0; i < NCH; i++) begin : g_reg
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        creg[i] <= `CCU_RST16;
      end else if (cap_now[i]) begin
        creg[i] <= t2;
      end else if (reg_wr_i && reg_idx_i == 4'(i)) begin
        if (reg_hi_i) begin
          creg[i][15:8] <= reg_data_i;
        end else begin
          creg[i][7:0] <= reg_data_i;
        end
      end
    end
  end

  // Compare channels
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    ccu_cmp_if ch ();
    if (i < NCC) begin : g_cc
      assign cc_mode[i] = ccu_pkg::ccu_cc_mode_t'(cc_mode_i[2*i +: 2]);
      assign cap_now[i] = (cc_mode[i] == ccu_pkg::CC_CAP_PIN && pin_edge[i])
                       || (cc_mode[i] == ccu_pkg::CC_CAP_WRITE && reg_wr_i
                           && !reg_hi_i && reg_idx_i == 4'(i));
      assign ch.tmr = t2;
      assign ch.upd = t2_upd;
      assign ch.ovf = t2_ovf_q;
      assign ch.en = cc_mode[i] == ccu_pkg::CC_COMPARE;
      assign ch.mode1 = cc_cmode1_i[i];
      assign ch.level = cc_level_i[i];
      assign ch.latch = 1'b0;
      assign oe_next[i] = cc_mode[i] == ccu_pkg::CC_COMPARE;
    end else begin : g_cm
      localparam int J = i - NCC;
      assign cap_now[i] = 1'b0;
      assign ch.tmr = cm_sel_i[J] ? ct : t2;
      assign ch.upd = cm_sel_i[J] ? ct_upd : t2_upd;
      assign ch.ovf = cm_sel_i[J] ? ct_ovf_q : t2_ovf_q;
      assign ch.en = cm_en_i[J];
      assign ch.mode1 = !cm_sel_i[J];
      assign ch.level = cm_level_i[J];
      assign ch.latch = cm_sel_i[J];
    end
    assign ch.val = creg[i];
    assign ch_out[i] = ch.out;
    assign ch_hit[i] = ch.hit;
    ccu_cmp_chan u_chan (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .bus    (ch.chan)
    );
  end

  // port 1 and port 4 lines
  assign cc_out_o = ch_out[NCC-1:0];
  assign cm_out_o = ch_out[NCH-1:NCC];

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cc_oe_o <= 5'h00;
    end else begin
      cc_oe_o <= oe_next;
    end
  end

  // port 5 lines on channel 4 in mode 1
  assign ccm_mask = (ch_hit[4] && cc_cmode1_i[4]) ? ccm_en_i : 8'h00;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ccm_out_o <= 8'h00;
    end else begin
      ccm_out_o <= (ccm_out_o & ~ccm_mask) | (ccm_level_i & ccm_mask);
    end
  end

  // external flags from pins and matches
  assign iex_ev = pin_edge | ch_hit[NCC-1:0];
  assign flag_set = {iex_ev[3:0], iex_ev[4], ct_ovf, ext_rld, t2_ovf};

  for (genvar k = 0; k < 8; k++) begin : g_flag
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        flags[k] <= 1'b0;
      end else if (flag_set[k]) begin
        flags[k] <= 1'b1;
      end else if (flag_clr_i[k]) begin
        flags[k] <= 1'b0;
      end
    end
  end

  assign flags_o = flags;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 7'h00;
      vec_o <= `CCU_VEC_NONE;
    end else begin
      irq_o <= {flags[7:3], flags[2], flags[1] | flags[0]};
      if (flags[1] | flags[0]) begin
        vec_o <= `CCU_VEC_T2;
      end else if (flags[2]) begin
        vec_o <= `CCU_VEC_CT;
      end else begin
        vec_o <= `CCU_VEC_NONE;
      end
    end
  end

  // Register and timer readback
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= `CCU_RST16;
    end else if (rd_idx_i < 4'(NCH)) begin
      rd_data_o <= creg[rd_idx_i];
    end else if (rd_idx_i == `CCU_IDX_T2) begin
      rd_data_o <= t2;
    end else if (rd_idx_i == `CCU_IDX_CT) begin
      rd_data_o <= ct;
    end else begin
      rd_data_o <= `CCU_RST16;
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  property p_t2_rate;
    t2_tick |=> !t2_tick [*8] ##1 !t2_tick [*3];
  endproperty
  a_t2_rate: assert property (p_t2_rate) else $error("timer 2 too fast");
  property p_ct_rate;
    ct_tick |=> !ct_tick;
  endproperty
  a_ct_rate: assert property (p_ct_rate) else $error("compare timer too fast");
  property p_auto;
    t2_ovf && rld == ccu_pkg::RLD_AUTO |=> t2 == $past(creg[0]) && flags[0];
  endproperty
  a_auto: assert property (p_auto) else $error("auto reload failed");
  property p_ext;
    ext_rld |=> t2 == $past(creg[0]) && flags[1];
  endproperty
  a_ext: assert property (p_ext) else $error("external reload failed");
  property p_ct_ovf;
    ct_ovf |=> ct == $past(ct_reload_i) && flags[2] ##1 irq_o[1];
  endproperty
  a_ct_ovf: assert property (p_ct_ovf) else $error("compare timer reload failed");
  property p_cap_pin;
    cc_mode[2] == ccu_pkg::CC_CAP_PIN && pin_edge[2] |=> creg[2] == $past(t2);
  endproperty
  a_cap_pin: assert property (p_cap_pin) else $error("pin capture failed");
  property p_cap_wr;
    cap_now[3] && cc_mode[3] == ccu_pkg::CC_CAP_WRITE |=> creg[3] == $past(t2);
  endproperty
  a_cap_wr: assert property (p_cap_wr) else $error("write capture failed");
  property p_vec;
    flags[1] |=> irq_o[0] && vec_o == `CCU_VEC_T2;
  endproperty
  a_vec: assert property (p_vec) else $error("shared vector wrong");
  c_ext: cover property (ext_rld);
  c_t2_ovf: cover property (t2_ovf && rld == ccu_pkg::RLD_AUTO);
  c_ct_ovf: cover property (ct_ovf);
  c_ccm: cover property (ccm_mask != 8'h00);
endmodule
